// File: wlbc_params.svh
`ifndef WLBC_PARAMS_SVH
`define WLBC_PARAMS_SVH

// clock rate
`define WLBC_CLK_MHZ   25
`define WLBC_CLK_KHZ   25000

// timing, in the unit printed
`define WLBC_SW_KHZ    600
`define WLBC_LOW_US    2500
`define WLBC_STEP_US   213
`define WLBC_HALF_US   5000
`define WLBC_SS_STEPS  32
`define WLBC_SS_SHIFT  5
`define WLBC_OVP_CYC   8

// counter widths
`define WLBC_TMR_W     17
`define WLBC_DIV_W     6
`define WLBC_OVP_W     4
`define WLBC_STEP_W    5

// register offsets
`define WLBC_OFS_CTRL  8'h00
`define WLBC_OFS_REF   8'h04
`define WLBC_OFS_STAT  8'h08
`define WLBC_OFS_FLT   8'h0c

// field positions, reset values and bus response codes
`define WLBC_CTRL_EN   0
`define WLBC_CTRL_SMON 1
`define WLBC_REF_RST   5'h1f
`define WLBC_RESP_OK   2'b00
`define WLBC_RESP_ERR  2'b10

`endif

// File: wlbc_pkg.sv
package wlbc_pkg;

  typedef enum logic [1:0] {
    WLBC_OFF,
    WLBC_RAMP,
    WLBC_RUN,
    WLBC_FAULT
  } wlbc_state_t;

  typedef struct packed {
    logic vbus;
    logic dim;
    logic low;
    logic hot;
    logic ovp;
    logic comp;
  } wlbc_pins_t;

  typedef struct packed {
    logic hot;
    logic uvlo;
    logic ovp;
  } wlbc_flt_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [4:0]  ss_step;
    logic        half_ilim;
    logic        hot;
    logic        uvlo;
    logic        sw_on;
    logic        active;
    wlbc_state_t state;
  } wlbc_stat_t;

endpackage

// File: wlbc_ctrl.sv
// Notes on behaviour
// - go active on bus power or driver enabled; stay while either holds
// - standby: bias and oscillator off, registers and shunt enable usable
// - active state runs oscillator and reference system
// - driver enabled by control pin rising edge or enable bit
// - enable bit set overrides and ignores the control pin
// - enable bit is on/off only; pin also dims by PWM
// - bit clear and pin low beyond 2.5 ms shuts driver down
// - 5-bit reference code, 0 to 200 mV, resets to 200 mV
// - fault disables driver, clears enable bit, holds until pin low long
// - supply below 2.2 V stops switching; restart when recovered
// - overtemperature turns driver off; auto release when cooled
// - soft start ramps reference in 32 steps of 213 us
// - half current limit for 5 ms after compensation ramps
// - overvoltage for eight switching cycles trips open-LED shutdown
// - after open-LED trip, stay off until pin or bit toggled
// - pin held high uses programmed code directly as target
// - PWM on pin chops the reference at the duty cycle
// - converter switches at fixed 600 kHz; the divider here is 25 MHz / 41, about 610 kHz
// - fault sets sticky fault bit and pulls open-drain interrupt low
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "wlbc_params.svh"

module wlbc_ctrl
  import wlbc_pkg::*;
#(
  parameter int unsigned LOW_CNT  = `WLBC_LOW_US * `WLBC_CLK_MHZ,
  parameter int unsigned STEP_CNT = `WLBC_STEP_US * `WLBC_CLK_MHZ,
  parameter int unsigned HALF_CNT = `WLBC_HALF_US * `WLBC_CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        vbus_present_i,
  input  wire logic        dim_ctrl_i,
  input  wire logic        supply_low_i,
  input  wire logic        temp_hot_i,
  input  wire logic        sw_ovp_i,
  input  wire logic        comp_ramped_i,
  output logic             active_o,
  output logic             osc_en_o,
  output logic             bias_en_o,
  output logic             smon_en_o,
  output logic             sw_en_o,
  output logic             sw_clk_o,
  output logic [4:0]       fb_ref_o,
  output logic             ref_chop_o,
  output logic             half_ilim_o,
  output logic             int_o,
  output logic             int_oe_n_o
);

  localparam int TW     = `WLBC_TMR_W;
  localparam int DW     = `WLBC_DIV_W;
  localparam int OW     = `WLBC_OVP_W;
  localparam int SW     = `WLBC_STEP_W;
  localparam int PW     = $bits(wlbc_pins_t);
  localparam int SW_DIV = `WLBC_CLK_KHZ / `WLBC_SW_KHZ;

  logic              rst_s1_q;
  logic              rst_sync_n_q;
  logic [PW-1:0]     pin_s1_q;
  logic [PW-1:0]     pin_s2_q;
  logic [PW-1:0]     pin_d1_q;
  logic [PW-1:0]     pin_raw;
  wlbc_pins_t        pin;
  wlbc_pins_t        pin_prev;
  logic              en_bit_q;
  logic              smon_q;
  logic [4:0]        ref_code_q;
  logic              pin_en_q;
  logic [TW-1:0]     low_cnt_q;
  logic              low_done;
  logic              low_pulse;
  wlbc_state_t       st_q;
  logic [SW-1:0]     ss_step_q;
  logic [TW-1:0]     step_cnt_q;
  logic [DW-1:0]     div_cnt_q;
  logic              sw_tick;
  logic [OW-1:0]     ovp_cnt_q;
  logic              ovp_trip;
  logic [TW-1:0]     half_cnt_q;
  logic              half_on_q;
  wlbc_flt_t         flt_q;
  wlbc_flt_t         flt_set;
  logic              flt_clr;
  logic              int_act_q;
  logic              run_req;
  logic              lock;
  logic              sw_on;
  logic [10:0]       ramp_prod;
  logic [4:0]        ref_d;
  logic [7:0]        aw_addr_q;
  logic              aw_v_q;
  logic [31:0]       w_data_q;
  logic              w_strb0_q;
  logic              w_v_q;
  logic              wr_fire;
  logic              wr_ctrl;
  logic              wr_ref;
  logic              rd_fire;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_d;
  wlbc_stat_t        stat;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q     <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_s1_q     <= 1'b1;
      rst_sync_n_q <= rst_s1_q;
    end
  end

  // pin synchronisers, plus one delay stage for edges
  assign pin = wlbc_pins_t'(pin_s2_q);
  assign pin_prev = wlbc_pins_t'(pin_d1_q);
  assign pin_raw  = {vbus_present_i, dim_ctrl_i, supply_low_i,
                     temp_hot_i, sw_ovp_i, comp_ramped_i};

  for (genvar i = 0; i < PW; i++) begin : g_sync
    always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
        pin_d1_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_d1_q[i] <= pin_s2_q[i];
      end
    end
  end

  assign run_req = en_bit_q | pin_en_q;
  assign lock    = pin.low | pin.hot;
  assign sw_on   = (st_q == WLBC_RAMP) || (st_q == WLBC_RUN);

  assign low_done  = (low_cnt_q == TW'(LOW_CNT));
  assign low_pulse = !pin.dim && (low_cnt_q == TW'(LOW_CNT - 1));

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      low_cnt_q <= '0;
    end else if (pin.dim) begin
      low_cnt_q <= '0;
    end else if (!low_done) begin
      low_cnt_q <= low_cnt_q + TW'(1);
    end
  end

  // pin enable latch
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pin_en_q <= 1'b0;
    end else if (ovp_trip || st_q == WLBC_FAULT) begin
      pin_en_q <= 1'b0;
    end else if (en_bit_q) begin
      pin_en_q <= !low_done;
    end else if (pin.dim && !pin_prev.dim) begin
      pin_en_q <= 1'b1;
    end else if (low_pulse) begin
      pin_en_q <= 1'b0;
    end
  end

  assign sw_tick = (div_cnt_q == DW'(SW_DIV - 1));

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      div_cnt_q <= '0;
    end else if (!active_o || sw_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + DW'(1);
    end
  end

  assign ovp_trip = sw_tick && sw_on && pin.ovp &&
                    (ovp_cnt_q == OW'(`WLBC_OVP_CYC - 1));

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      ovp_cnt_q <= '0;
    end else if (!sw_on) begin
      ovp_cnt_q <= '0;
    end else if (sw_tick) begin
      ovp_cnt_q <= pin.ovp ? ovp_cnt_q + OW'(1) : '0;
    end
  end

  // driver state machine
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      st_q       <= WLBC_OFF;
      ss_step_q  <= '0;
      step_cnt_q <= '0;
    end else begin
      case (st_q)
        WLBC_OFF: begin
          ss_step_q  <= '0;
          step_cnt_q <= '0;
          if (run_req && !lock) begin
            st_q <= WLBC_RAMP;
          end
        end
        WLBC_RAMP, WLBC_RUN: begin
          if (ovp_trip) begin
            st_q <= WLBC_FAULT;
          end else if (!run_req || lock) begin
            st_q <= WLBC_OFF;
          end else if (st_q == WLBC_RAMP) begin
            if (step_cnt_q == TW'(STEP_CNT - 1)) begin
              step_cnt_q <= '0;
              if (ss_step_q == SW'(`WLBC_SS_STEPS - 1)) begin
                st_q <= WLBC_RUN;
              end else begin
                ss_step_q <= ss_step_q + SW'(1);
              end
            end else begin
              step_cnt_q <= step_cnt_q + TW'(1);
            end
          end
        end
        WLBC_FAULT: begin
          if (low_done) begin
            st_q <= WLBC_OFF;
          end
        end
        default: begin
          st_q <= WLBC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      half_on_q  <= 1'b0;
      half_cnt_q <= '0;
    end else if (!sw_on) begin
      half_on_q  <= 1'b0;
      half_cnt_q <= '0;
    end else if (pin.comp && !pin_prev.comp) begin
      half_on_q  <= 1'b1;
      half_cnt_q <= '0;
    end else if (half_on_q) begin
      if (half_cnt_q == TW'(HALF_CNT - 1)) begin
        half_on_q <= 1'b0;
      end else begin
        half_cnt_q <= half_cnt_q + TW'(1);
      end
    end
  end

  // reference target
  assign ramp_prod = ({6'h00, ss_step_q} + 11'h001) * {6'h00, ref_code_q};

  always_comb begin
    ref_d = 5'h00;
    if (st_q == WLBC_RAMP) begin
      ref_d = 5'(ramp_prod >> `WLBC_SS_SHIFT);
    end else if (st_q == WLBC_RUN) begin
      ref_d = ref_code_q;
    end
  end

  // pin-facing outputs
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      active_o    <= 1'b0;
      osc_en_o    <= 1'b0;
      bias_en_o   <= 1'b0;
      smon_en_o   <= 1'b0;
      sw_en_o     <= 1'b0;
      sw_clk_o    <= 1'b0;
      fb_ref_o    <= 5'h00;
      ref_chop_o  <= 1'b0;
      half_ilim_o <= 1'b0;
    end else begin
      active_o    <= pin.vbus | run_req | (st_q != WLBC_OFF);
      osc_en_o    <= pin.vbus | run_req | (st_q != WLBC_OFF);
      bias_en_o   <= pin.vbus | run_req | (st_q != WLBC_OFF);
      smon_en_o   <= smon_q;
      sw_en_o     <= sw_on & !lock & !ovp_trip;
      sw_clk_o    <= sw_on && (div_cnt_q < DW'(SW_DIV / 2));
      fb_ref_o    <= ref_d;
      ref_chop_o  <= sw_on & (en_bit_q | pin.dim);
      half_ilim_o <= half_on_q;
    end
  end

  // sticky fault bits, set wins over read clear
  assign flt_set = {pin.hot & !pin_prev.hot, pin.low & !pin_prev.low,
                    ovp_trip};
  assign flt_clr = rd_fire && (s_axi_araddr_i == `WLBC_OFS_FLT);

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      flt_q     <= '0;
      int_act_q <= 1'b0;
    end else begin
      flt_q     <= (flt_clr ? '0 : flt_q) | flt_set;
      int_act_q <= (int_act_q & !flt_clr) | (|flt_set);
    end
  end

  // open-drain data held low, enable does the signalling
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      int_o      <= 1'b0;
      int_oe_n_o <= 1'b1;
    end else begin
      int_o      <= 1'b0;
      int_oe_n_o <= !((int_act_q & !flt_clr) | (|flt_set));
    end
  end

  // bus write channels
  assign wr_fire = aw_v_q && w_v_q && !s_axi_bvalid_o;
  assign wr_ctrl = wr_fire && w_strb0_q && (aw_addr_q == `WLBC_OFS_CTRL);
  assign wr_ref  = wr_fire && w_strb0_q && (aw_addr_q == `WLBC_OFS_REF);

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      aw_v_q          <= 1'b0;
      aw_addr_q       <= 8'h00;
      s_axi_awready_o <= 1'b0;
      w_v_q           <= 1'b0;
      w_data_q        <= 32'h0000_0000;
      w_strb0_q       <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `WLBC_RESP_OK;
    end else begin
      if (!aw_v_q && !s_axi_awready_o && !s_axi_bvalid_o) begin
        s_axi_awready_o <= 1'b1;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
        aw_v_q          <= 1'b1;
        aw_addr_q       <= s_axi_awaddr_i;
      end
      if (!w_v_q && !s_axi_wready_o && !s_axi_bvalid_o) begin
        s_axi_wready_o <= 1'b1;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
        w_v_q          <= 1'b1;
        w_data_q       <= s_axi_wdata_i;
        w_strb0_q      <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        aw_v_q         <= 1'b0;
        w_v_q          <= 1'b0;
        if (aw_addr_q == `WLBC_OFS_CTRL || aw_addr_q == `WLBC_OFS_REF ||
            aw_addr_q == `WLBC_OFS_STAT || aw_addr_q == `WLBC_OFS_FLT) begin
          s_axi_bresp_o <= `WLBC_RESP_OK;
        end else begin
          s_axi_bresp_o <= `WLBC_RESP_ERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // control bits
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      en_bit_q   <= 1'b0;
      smon_q     <= 1'b0;
      ref_code_q <= `WLBC_REF_RST;
    end else begin
      if (ovp_trip) begin
        en_bit_q <= 1'b0;
      end else if (wr_ctrl) begin
        en_bit_q <= w_data_q[`WLBC_CTRL_EN];
      end
      if (wr_ctrl) begin
        smon_q <= w_data_q[`WLBC_CTRL_SMON];
      end
      if (wr_ref) begin
        ref_code_q <= w_data_q[4:0];
      end
    end
  end

  // bus read channel
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  always_comb begin
    stat         = '0;
    stat.state   = st_q;
    stat.active  = active_o;
    stat.sw_on   = sw_on;
    stat.uvlo    = pin.low;
    stat.hot     = pin.hot;
    stat.half_ilim = half_on_q;
    stat.ss_step = ss_step_q;
    rdata_d      = 32'h0000_0000;
    rresp_d      = `WLBC_RESP_OK;
    if (s_axi_araddr_i == `WLBC_OFS_CTRL) begin
      rdata_d[`WLBC_CTRL_EN]   = en_bit_q;
      rdata_d[`WLBC_CTRL_SMON] = smon_q;
    end else if (s_axi_araddr_i == `WLBC_OFS_REF) begin
      rdata_d[4:0] = ref_code_q;
    end else if (s_axi_araddr_i == `WLBC_OFS_STAT) begin
      rdata_d = stat;
    end else if (s_axi_araddr_i == `WLBC_OFS_FLT) begin
      rdata_d[2:0] = flt_q;
    end else begin
      rresp_d = `WLBC_RESP_ERR;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `WLBC_RESP_OK;
    end else if (rd_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rdata_d;
      s_axi_rresp_o   <= rresp_d;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
    end else if (!s_axi_rvalid_o) begin
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

// File: wlbc_ctrl_properties.sv
module wlbc_ctrl_properties
  import wlbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic vbus_present_i,
  input wire logic supply_low_i,
  input wire logic temp_hot_i,
  input wire logic sw_ovp_i,
  input wire logic active_o,
  input wire logic osc_en_o,
  input wire logic bias_en_o,
  input wire logic sw_en_o,
  input wire logic sw_clk_o,
  input wire logic ref_chop_o,
  input wire logic half_ilim_o,
  input wire logic int_o,
  input wire logic int_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [5:0] cnt_q;
  logic [9:0] ovp_q;
  logic       prv_q;
  logic [1:0] seen_q;

  // cycles since last switching clock rise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 6'h00;
      prv_q  <= 1'b0;
      seen_q <= 2'h0;
    end else begin
      prv_q  <= sw_clk_o;
      cnt_q  <= (sw_clk_o && !prv_q) ? 6'h00 : cnt_q + 6'h01;
      // first pulse after start may be partial, so skip it
      if (!sw_en_o)
        seen_q <= 2'h0;
      else if (sw_clk_o && !prv_q && seen_q != 2'h2)
        seen_q <= seen_q + 2'h1;
    end
  end

  // overvoltage seen while switching
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovp_q <= 10'h000;
    end else begin
      ovp_q <= (sw_ovp_i && sw_en_o) ? ovp_q + 10'h001 : 10'h000;
    end
  end

  property p_osc; osc_en_o == active_o && bias_en_o == active_o; endproperty
  property p_vbus; vbus_present_i [*6] |=> active_o; endproperty
  property p_uvlo; supply_low_i [*6] |=> !sw_en_o; endproperty
  property p_hot; temp_hot_i [*6] |=> !sw_en_o; endproperty
  property p_clk;
    sw_clk_o && !prv_q && seen_q == 2'h2 |-> cnt_q == 6'h28;
  endproperty
  property p_ovp; ovp_q < 10'h1c2; endproperty
  property p_chop; ref_chop_o |-> sw_en_o || $past(sw_en_o); endproperty
  property p_half; $rose(half_ilim_o) |-> half_ilim_o [*8]; endproperty
  property p_int; int_o == 1'b0; endproperty
  property p_flt_int; $rose(supply_low_i) |-> ##3 !int_oe_n_o; endproperty

  a_osc: assert property (p_osc)
    else $error("oscillator does not follow active");
  a_vbus: assert property (p_vbus)
    else $error("bus power did not activate");
  a_uvlo: assert property (p_uvlo)
    else $error("switching under low supply");
  a_hot: assert property (p_hot)
    else $error("switching while hot");
  a_clk: assert property (p_clk)
    else $error("switching period wrong");
  a_ovp: assert property (p_ovp)
    else $error("overvoltage did not stop switch");
  a_chop: assert property (p_chop)
    else $error("chop gate open while off");
  a_half: assert property (p_half)
    else $error("half limit window short");
  a_int: assert property (p_int)
    else $error("interrupt data not low");
  a_flt_int: assert property (p_flt_int)
    else $error("fault did not pull interrupt");

  c_run: cover property ($rose(sw_en_o));
  c_half: cover property ($rose(half_ilim_o));
  c_flt: cover property ($fell(int_oe_n_o));
endmodule

bind wlbc_ctrl wlbc_ctrl_properties u_wlbc_ctrl_properties (.*);

// File: wlbc_led_model.sv
module wlbc_led_model (
  input  wire logic clk_i,
  input  wire logic sw_en_i,
  input  wire logic open_i,
  output logic      sw_ovp_o,
  output logic      comp_ramped_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] dly_q;

  initial begin
    sw_ovp_o      = 1'b0;
    comp_ramped_o = 1'b0;
    dly_q         = 3'h0;
  end

  // open string: switch node overshoots while switching
  always @(posedge clk_i) begin
    sw_ovp_o <= open_i && sw_en_i;
  end

  // loop settles a few cycles after switching starts
  always @(posedge clk_i) begin
    if (!sw_en_i)
      dly_q <= 3'h0;
    else if (dly_q != 3'h7)
      dly_q <= dly_q + 3'h1;
    comp_ramped_o <= sw_en_i && dly_q == 3'h7;
  end
endmodule

// File: white_led_boost_control_bench.sv
module white_led_boost_control_bench;
  import wlbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awvalid_i = 1'b0;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic        vbus_present_i = 1'b0;
  logic        dim_ctrl_i = 1'b0;
  logic        supply_low_i = 1'b0;
  logic        temp_hot_i = 1'b0;
  logic        open_q = 1'b0;
  logic        sw_ovp_i, comp_ramped_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic        active_o, osc_en_o, bias_en_o, smon_en_o, sw_en_o;
  logic        sw_clk_o, ref_chop_o, half_ilim_o, int_o, int_oe_n_o;
  logic [4:0]  fb_ref_o;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_errors = 0;
  int          n_checks = 0;

  wlbc_ctrl #(.LOW_CNT(20), .STEP_CNT(4), .HALF_CNT(30)) u_wlbc_ctrl (.*);
  wlbc_led_model u_wlbc_led_model (
    .clk_i         (clk_i),
    .sw_en_i       (sw_en_o),
    .open_i        (open_q),
    .sw_ovp_o      (sw_ovp_i),
    .comp_ramped_o (comp_ramped_i)
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!(s_axi_bvalid_o && s_axi_bready_i));
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!(s_axi_rvalid_o && s_axi_rready_i));
    rd  = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 200; i++) begin
      rd_reg(8'h08);
      if (rd[1:0] === s) break;
    end
    chk(rd[1:0], s, "state not reached");
  endtask

  task automatic t_reset();
    rd_reg(8'h04);
    chk(rd, 32'h1f, "reference reset");
    rd_reg(8'h10);
    chk(rsp, 2'b10, "unmapped response");
    wr(8'h00, 32'h2);
    @(negedge clk_i);
    chk({smon_en_o, active_o, osc_en_o}, 3'h4, "standby shunt");
    wr(8'h00, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_vbus();
    @(posedge clk_i);
    vbus_present_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk({active_o, bias_en_o}, 2'h3, "bus power wake");
    @(posedge clk_i);
    vbus_present_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(active_o, 1'b0, "back to standby");
    $display("t_vbus done");
  endtask

  task automatic t_bit();
    wr(8'h04, 32'h0a);
    wr(8'h00, 32'h1);
    repeat (40) @(negedge clk_i);
    chk(fb_ref_o > 5'h00 && fb_ref_o < 5'h0a, 1'b1, "ramp midway");
    wait_st(2'h2);
    repeat (30) @(negedge clk_i);
    chk({sw_en_o, fb_ref_o}, 6'h2a, "bit ignores low pin");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(8'h00, 32'h0);
    rd_reg(8'h08);
    chk(rd[1:0], 2'h2, "pin holds driver");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b0;
    rd_reg(8'h08);
    chk(rd[1:0], 2'h2, "early shutdown");
    wait_st(2'h0);
    $display("t_bit done");
  endtask

  task automatic t_pin();
    @(posedge clk_i);
    dim_ctrl_i <= 1'b1;
    wait_st(2'h2);
    @(negedge clk_i);
    chk({ref_chop_o, fb_ref_o}, 6'h2a, "steady pin level");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk({sw_en_o, ref_chop_o}, 2'h2, "chop on low");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk(ref_chop_o, 1'b1, "chop on high");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      {temp_hot_i, supply_low_i} <= (i != 0) ? 2'b10 : 2'b01;
      repeat (8) @(negedge clk_i);
      chk(sw_en_o, 1'b0, "lockout");
      @(posedge clk_i);
      {temp_hot_i, supply_low_i} <= 2'b00;
      wait_st(2'h2);
    end
    @(negedge clk_i);
    chk(int_oe_n_o, 1'b0, "interrupt pulled");
    rd_reg(8'h0c);
    chk(rd, 32'h6, "lockout flags");
    @(negedge clk_i);
    chk(int_oe_n_o, 1'b1, "interrupt released");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b0;
    wait_st(2'h0);
    $display("t_pin done");
  endtask

  task automatic t_open();
    @(posedge clk_i);
    dim_ctrl_i <= 1'b1;
    wr(8'h00, 32'h1);
    for (int i = 0; i < 50 && sw_en_o !== 1'b1; i++) @(negedge clk_i);
    repeat (20) @(negedge clk_i);
    chk(half_ilim_o, 1'b1, "half limit on");
    repeat (40) @(negedge clk_i);
    chk(half_ilim_o, 1'b0, "half limit off");
    wait_st(2'h2);
    open_q <= 1'b1;
    wait_st(2'h3);
    repeat (30) @(negedge clk_i);
    chk({sw_en_o, int_oe_n_o}, 2'h0, "fault held");
    open_q <= 1'b0;
    rd_reg(8'h00);
    chk(rd[0], 1'b0, "enable cleared");
    @(posedge clk_i);
    dim_ctrl_i <= 1'b0;
    rd_reg(8'h08);
    chk(rd[1:0], 2'h3, "fault until pin low");
    wait_st(2'h0);
    repeat (30) @(posedge clk_i);
    rd_reg(8'h08);
    chk(rd[1:0], 2'h0, "stays off");
    rd_reg(8'h0c);
    chk(rd[0], 1'b1, "open flag");
    wr(8'h00, 32'h1);
    wait_st(2'h2);
    wr(8'h00, 32'h0);
    wait_st(2'h0);
    $display("t_open done");
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_vbus();
    t_bit();
    t_pin();
    t_open();
    wrap_up();
  end
endmodule
